// File: design/cti_top.sv
// cascaded three-bank interrupt controller with apb registers
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/10ps
`default_nettype none
module cti_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [cti_pkg::NEXT-1:0] ext_req_n,
  input wire logic shared_request_timer_pin_i,
  output logic shared_request_timer_pin_o,
  output logic shared_request_timer_pin_oe,
  input wire logic shared_request_dma_pin_n,
  output logic dma_request_ch_four,
  input wire logic second_timer_output,
  input wire logic timer0_out,
  input wire logic timer3_out,
  input wire logic dma_chain_req,
  input wire logic dma_tc_req,
  input wire logic m_io_n,
  input wire logic d_c_n,
  input wire logic w_r_n,
  input wire logic ads_n,
  input wire logic ready_n,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic int_out
);
  import cti_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [NSYNC-1:0] s;
  logic [NEXT-1:0] s_ext;
  logic s_pin3, s_pin9, s_mio, s_dc, s_wr, s_ads, s_rdy;

  cti_sync #(.W(NSYNC), .INIT('1)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({ready_n, ads_n, w_r_n, d_c_n, m_io_n,
        shared_request_dma_pin_n, shared_request_timer_pin_i,
        ext_req_n}),
    .q(s)
  );
  assign s_ext = s[12:0];
  assign s_pin3 = s[13];
  assign s_pin9 = s[14];
  assign s_mio = s[15];
  assign s_dc = s[16];
  assign s_wr = s[17];
  assign s_ads = s[18];
  assign s_rdy = s[19];

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [2:0] ctrl_q, ctrl_d;
  logic [7:0] vec_q [NVEC];
  logic [7:0] vec_d [NVEC];
  logic [7:0] iw2_q [NBANK];
  logic [7:0] iw2_d [NBANK];
  logic [1:0] iw2_last_q, iw2_last_d;
  logic p15_q, p15_d;
  logic t0_prev_q, t3_prev_q, t0_req_q, t0_req_d, t3_req_q, t3_req_d;
  logic ads_prev_q;
  cti_state_t state_q, state_d;
  logic [4:0] idx_q, idx_d;
  logic slave_q, slave_d;
  logic [7:0] data_q, data_d;
  logic oe_q, oe_d, int_q, pin3_oe_q, pin3_oe_d, dmareq_q, dmareq_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;

  // ----------------------------------------
  // banks
  // ----------------------------------------
  logic [7:0] bk_req [NBANK];
  logic [7:0] bk_mask [NBANK];
  logic [7:0] bk_slave [NBANK];
  logic [7:0] bk_pend [NBANK];
  logic [7:0] bk_insvc [NBANK];
  logic [2:0] bk_sel [NBANK];
  logic [NBANK-1:0] bk_any, bk_ack, res_ack;
  logic [NBANK-1:0] mask_we, slave_we, eoi_we;
  logic pin3_req, pin9_req;

  assign pin3_req = ~s_pin3 & (ctrl_q[1:0] != MODE_TMR_ONLY);
  assign pin9_req = ~s_pin9 & ~ctrl_q[CTRL_DMA_BIT];
  // first bank: 0 tmr3, 1 chain, 2 bank b or 1.5, 3 pin, 4 tc; 5,6,7 unused
  assign bk_req[0] = {3'h0, dma_tc_req, pin3_req,
                      bk_any[1] | p15_q, dma_chain_req, t3_req_q};
  assign bk_req[1] = {~s_ext[4:0], bk_any[2], pin9_req, t0_req_q};
  assign bk_req[2] = ~s_ext[12:5];

  genvar g;
  generate
    for (g = 0; g < NBANK; g++) begin : gen_bank
      cti_bank #(.N(NLINE)) u_bank (
        .pclk(pclk),
        .presetn(presetn),
        .req(bk_req[g]),
        .mask_we(mask_we[g]),
        .slave_we(slave_we[g]),
        .eoi_we(eoi_we[g]),
        .wdata(pwdata[7:0]),
        .ack(bk_ack[g]),
        .mask(bk_mask[g]),
        .slave(bk_slave[g]),
        .pend(bk_pend[g]),
        .insvc(bk_insvc[g]),
        .sel(bk_sel[g]),
        .any(bk_any[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  function automatic logic bank_hit(input logic [7:0] a, input int b,
                                    input logic [7:0] r);
    return a == OFF_BANK + 8'(b) * BANK_STRIDE + r;
  endfunction

  logic wr_go, rd_go, vhit;
  logic [5:0] vword;
  logic [4:0] vidx;
  assign wr_go = psel & penable & pready_q & pwrite;
  assign rd_go = psel & penable & pready_q & ~pwrite;
  assign vword = paddr[7:2];
  assign vidx = 5'(vword - VEC_FIRST_WORD);
  assign vhit = (paddr[1:0] == 2'h0) && (vword >= VEC_FIRST_WORD) &&
                (vword <= VEC_LAST_WORD);

  always_comb begin
    ctrl_d = ctrl_q;
    vec_d = vec_q;
    iw2_d = iw2_q;
    iw2_last_d = iw2_last_q;
    p15_d = p15_q;
    mask_we = '0;
    slave_we = '0;
    eoi_we = '0;
    pready_d = psel & penable & ~pready_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (pready_d) begin
      prdata_d = 32'h0000_0000;
      if (paddr == OFF_CTRL) begin
        prdata_d = {29'h0, ctrl_q};
      end else if (paddr == OFF_PEND) begin
        prdata_d = {6'h0, int_q, p15_q, bk_pend[2], bk_pend[1], bk_pend[0]};
      end else if (paddr == OFF_INSVC) begin
        prdata_d = {8'h0, bk_insvc[2], bk_insvc[1], bk_insvc[0]};
      end else if (vhit) begin
        prdata_d = {24'h0, vec_q[vidx]};
      end else begin
        pslverr_d = 1'b1;
      end
      for (int b = 0; b < NBANK; b++) begin
        if (bank_hit(paddr, b, REG_MASK)) begin
          prdata_d = {24'h0, bk_mask[b]};
          pslverr_d = 1'b0;
        end else if (bank_hit(paddr, b, REG_SLAVE)) begin
          prdata_d = {24'h0, bk_slave[b]};
          pslverr_d = 1'b0;
        end else if (bank_hit(paddr, b, REG_IW2)) begin
          prdata_d = {24'h0, iw2_q[b]};
          pslverr_d = 1'b0;
        end else if (bank_hit(paddr, b, REG_EOI)) begin
          pslverr_d = 1'b0;
        end
      end
    end
    // error flag stands only beside pready
    if (rd_go && bank_hit(paddr, 32'(iw2_last_q), REG_IW2)) begin
      p15_d = 1'b0;
    end
    if (wr_go) begin
      if (paddr == OFF_CTRL) begin
        ctrl_d = pwdata[2:0];
      end
      if (vhit) begin
        vec_d[vidx] = pwdata[7:0];
      end
      for (int b = 0; b < NBANK; b++) begin
        mask_we[b] = bank_hit(paddr, b, REG_MASK);
        slave_we[b] = bank_hit(paddr, b, REG_SLAVE);
        eoi_we[b] = bank_hit(paddr, b, REG_EOI);
        if (bank_hit(paddr, b, REG_IW2)) begin
          iw2_d[b] = pwdata[7:0];
          iw2_last_d = 2'(b);
          p15_d = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // acknowledge sequencer
  // ----------------------------------------
  logic ads_fall, ack_start;
  logic [4:0] res_idx;
  logic res_slave;
  assign ads_fall = ~s_ads & ads_prev_q;
  assign ack_start = ads_fall & ~s_mio & ~s_dc & ~s_wr;

  always_comb begin
    res_idx = DEF_IDX;
    res_slave = 1'b0;
    res_ack = '0;
    if (bk_any[0]) begin
      res_ack[0] = 1'b1;
      if (bk_sel[0] != CASC_LINE) begin
        res_idx = {2'h0, bk_sel[0]};
        res_slave = bk_slave[0][bk_sel[0]];
      end else if (p15_q) begin
        res_idx = P15_IDX;
      end else if (bk_any[1]) begin
        res_ack[1] = 1'b1;
        if (bk_sel[1] == CASC_LINE && bk_any[2]) begin
          res_ack[2] = 1'b1;
          res_idx = {2'h2, bk_sel[2]};
          res_slave = bk_slave[2][bk_sel[2]];
        end else begin
          res_idx = {2'h1, bk_sel[1]};
          res_slave = bk_slave[1][bk_sel[1]];
        end
      end
    end
  end

  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    slave_d = slave_q;
    data_d = data_q;
    oe_d = oe_q;
    bk_ack = '0;
    unique case (state_q)
      CS_IDLE: begin
        if (ack_start) begin
          bk_ack = res_ack;
          idx_d = res_idx;
          slave_d = res_slave;
          data_d = res_slave ? vec_q[res_idx] : FIRST_BYTE;
          oe_d = 1'b1;
          state_d = CS_FIRST;
        end
      end
      CS_FIRST: begin
        if (!s_rdy) begin
          oe_d = 1'b0;
          state_d = CS_GAP;
        end
      end
      CS_GAP: begin
        if (ack_start) begin
          data_d = vec_q[idx_q];
          oe_d = ~slave_q;
          state_d = CS_SECOND;
        end
      end
      CS_SECOND: begin
        if (!s_rdy) begin
          oe_d = 1'b0;
          state_d = CS_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------
  // timer edge requests and pins
  // ----------------------------------------
  always_comb begin
    t3_req_d = (timer3_out & ~t3_prev_q) |
               (t3_req_q & ~bk_mask[0][0] &
                ~(bk_ack[0] && idx_d == T3_IDX));
    t0_req_d = (timer0_out & ~t0_prev_q) |
               (t0_req_q & ~bk_mask[1][0] &
                ~(bk_ack[1] && idx_d == T0_IDX));
    pin3_oe_d = (ctrl_q[1:0] != MODE_REQ_ONLY) & second_timer_output;
    dmareq_d = ctrl_q[CTRL_DMA_BIT] & s_pin9;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      for (int i = 0; i < NVEC; i++) begin
        vec_q[i] <= VEC_RESET;
      end
      for (int b = 0; b < NBANK; b++) begin
        iw2_q[b] <= VEC_RESET;
      end
      iw2_last_q <= 2'h0;
      p15_q <= 1'b0;
      t0_prev_q <= 1'b0;
      t3_prev_q <= 1'b0;
      t0_req_q <= 1'b0;
      t3_req_q <= 1'b0;
      ads_prev_q <= 1'b1;
      state_q <= CS_IDLE;
      idx_q <= DEF_IDX;
      slave_q <= 1'b0;
      data_q <= FIRST_BYTE;
      oe_q <= 1'b0;
      int_q <= 1'b0;
      pin3_oe_q <= 1'b0;
      dmareq_q <= 1'b0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      vec_q <= vec_d;
      iw2_q <= iw2_d;
      iw2_last_q <= iw2_last_d;
      p15_q <= p15_d;
      t0_prev_q <= timer0_out;
      t3_prev_q <= timer3_out;
      t0_req_q <= t0_req_d;
      t3_req_q <= t3_req_d;
      ads_prev_q <= s_ads;
      state_q <= state_d;
      idx_q <= idx_d;
      slave_q <= slave_d;
      data_q <= data_d;
      oe_q <= oe_d;
      int_q <= bk_any[0];
      pin3_oe_q <= pin3_oe_d;
      dmareq_q <= dmareq_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // open-drain: pin is only ever pulled low
  assign shared_request_timer_pin_o = 1'b0;
  assign shared_request_timer_pin_oe = pin3_oe_q;
  assign dma_request_ch_four = dmareq_q;
  assign data_out = data_q;
  assign data_oe = oe_q;
  assign int_out = int_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule
`default_nettype wire

// File: pkg/cti_pkg.sv
// constants and types for the cascaded three-bank interrupt controller
package cti_pkg;
  localparam int NBANK = 3;
  localparam int NLINE = 8;
  localparam int NVEC = 25;
  localparam int NSYNC = 20;
  localparam int NEXT = 13;
  // apb byte offsets; the vector range is given as word indices (paddr[7:2])
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PEND = 8'h04;
  localparam logic [7:0] OFF_INSVC = 8'h08;
  localparam logic [7:0] OFF_BANK = 8'h10;
  localparam logic [7:0] BANK_STRIDE = 8'h10;
  localparam logic [7:0] REG_MASK = 8'h00;
  localparam logic [7:0] REG_SLAVE = 8'h04;
  localparam logic [7:0] REG_IW2 = 8'h08;
  localparam logic [7:0] REG_EOI = 8'h0C;
  localparam logic [5:0] VEC_FIRST_WORD = 6'h10;
  localparam logic [5:0] VEC_LAST_WORD = 6'h28;
  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DMA_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] MODE_REQ_ONLY = 2'h0;
  localparam logic [1:0] MODE_TMR_ONLY = 2'h1;
  localparam logic [1:0] MODE_TMR_REQ = 2'h2;
  // interrupt structure
  localparam logic [2:0] CASC_LINE = 3'h2;
  localparam logic [4:0] DEF_IDX = 5'h07;
  localparam logic [4:0] P15_IDX = 5'h18;
  localparam logic [4:0] T3_IDX = 5'h00;
  localparam logic [4:0] T0_IDX = 5'h08;
  localparam logic [7:0] FIRST_BYTE = 8'h00;
  localparam logic [7:0] VEC_RESET = 8'h00;
  typedef enum logic [1:0] {
    CS_IDLE,
    CS_FIRST,
    CS_GAP,
    CS_SECOND
  } cti_state_t;
endpackage

// File: design/cti_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module cti_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule
`default_nettype wire

// File: design/cti_bank.sv
// one interrupt bank: pending, in-service, mask, resolver
`timescale 1ns/10ps
`default_nettype none
module cti_bank #(
  parameter int N = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N-1:0] req,
  input wire logic mask_we,
  input wire logic slave_we,
  input wire logic eoi_we,
  input wire logic [N-1:0] wdata,
  input wire logic ack,
  output logic [N-1:0] mask,
  output logic [N-1:0] slave,
  output logic [N-1:0] pend,
  output logic [N-1:0] insvc,
  output logic [2:0] sel,
  output logic any
);
  logic [N-1:0] pend_q, pend_d, insvc_q, insvc_d, mask_q, mask_d;
  logic [N-1:0] slave_q, slave_d, elig, set_v;
  logic blk;

  // ----------------------------------------
  // priority resolver
  // ----------------------------------------
  always_comb begin
    blk = 1'b0;
    elig = '0;
    sel = 3'h0;
    for (int i = 0; i < N; i++) begin
      blk = blk | insvc_q[i];
      elig[i] = pend_q[i] & ~mask_q[i] & ~blk;
    end
    for (int i = N - 1; i >= 0; i--) begin
      if (elig[i]) begin
        sel = 3'(i);
      end
    end
    any = |elig;
  end

  // ----------------------------------------
  // register next values
  // ----------------------------------------
  always_comb begin
    set_v = '0;
    if (ack && any) begin
      set_v[sel] = 1'b1;
    end
    pend_d = req & ~mask_q;
    insvc_d = (insvc_q & ~(eoi_we ? wdata : '0)) | set_v;
    mask_d = mask_we ? wdata : mask_q;
    slave_d = slave_we ? wdata : slave_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= '0;
      insvc_q <= '0;
      mask_q <= '0;
      slave_q <= '0;
    end else begin
      pend_q <= pend_d;
      insvc_q <= insvc_d;
      mask_q <= mask_d;
      slave_q <= slave_d;
    end
  end

  assign mask = mask_q;
  assign slave = slave_q;
  assign pend = pend_q;
  assign insvc = insvc_q;
endmodule
`default_nettype wire

// File: verification/cti_checker.sv
// port-level assertions for the cascaded interrupt controller
`timescale 1ns/10ps
`default_nettype none
module cti_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic m_io_n,
  input wire logic d_c_n,
  input wire logic w_r_n,
  input wire logic ads_n,
  input wire logic ready_n,
  input wire logic second_timer_output,
  input wire logic shared_request_timer_pin_oe,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  logic ads_q, odd_q, odd_d, ack_go, oth_go;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // falling address strobe with acknowledge or other code
  assign ack_go = ads_q && !ads_n && !m_io_n && !d_c_n && !w_r_n;
  assign oth_go = ads_q && !ads_n && (m_io_n || d_c_n || w_r_n);
  always_comb begin
    odd_d = ack_go ? !odd_q : odd_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ads_q <= 1'b1;
      odd_q <= 1'b0;
    end else begin
      ads_q <= ads_n;
      odd_q <= odd_d;
    end
  end
  a_ack_answer: assert property (
    ack_go && !odd_q |-> ##[2:6] data_oe)
    else $error("first acknowledge not answered");
  a_other_code: assert property (
    oth_go |=> !data_oe [*6])
    else $error("bus driven on non-acknowledge cycle");
  a_oe_release: assert property (
    data_oe && !ready_n |-> ##[1:5] !data_oe)
    else $error("data bus not released after ready");
  a_oe_hold: assert property (
    data_oe && ready_n && $past(ready_n) && $past(ready_n, 2)
    && $past(ready_n, 3) |=> data_oe)
    else $error("data bus dropped before ready");
  a_vec_stable: assert property (
    data_oe && $past(data_oe) |-> $stable(data_out))
    else $error("acknowledge byte changed while driven");
  a_oe_cause: assert property (
    $rose(data_oe) |-> !ads_n && !m_io_n && !d_c_n && !w_r_n)
    else $error("bus driven without acknowledge");
  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (
    pslverr |-> pready && psel && penable)
    else $error("pslverr outside completion");
  a_timer_quiet: assert property (
    !second_timer_output [*3] |-> !shared_request_timer_pin_oe)
    else $error("pin pulled without timer output");
  c_second_ack: cover property (ack_go && odd_q);
  c_vector_out: cover property (data_oe && data_out != 8'h00);
  c_slverr: cover property (pslverr);
  c_timer_pin: cover property (shared_request_timer_pin_oe);
endmodule
`default_nettype wire

// File: verification/cti_host_model.sv
// host model issuing interrupt acknowledge bus cycles
`timescale 1ns/10ps
`default_nettype none
module cti_host_model (
  input wire logic pclk,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic m_io_n,
  output logic d_c_n,
  output logic w_r_n,
  output logic ads_n,
  output logic ready_n
);
  initial begin
    {m_io_n, d_c_n, w_r_n} = 3'h7;
    ads_n = 1'b1;
    ready_n = 1'b1;
  end
  task automatic cycle(input logic [2:0] code, output logic [7:0] b,
                       output logic seen);
    int n;
    seen = 1'b0;
    b = 8'h00;
    @(posedge pclk);
    {m_io_n, d_c_n, w_r_n} <= code;
    ads_n <= 1'b0;
    for (n = 0; n < 10 && !seen; n++) begin
      @(posedge pclk);
      if (data_oe === 1'b1) begin
        seen = 1'b1;
        b = data_out;
      end
    end
    @(posedge pclk);
    ready_n <= 1'b0;
    for (n = 0; n < 10 && data_oe !== 1'b0; n++) @(posedge pclk);
    @(posedge pclk);
    ads_n <= 1'b1;
    ready_n <= 1'b1;
    {m_io_n, d_c_n, w_r_n} <= 3'h7;
    repeat (4) @(posedge pclk);
  endtask
  task automatic ack(output logic [7:0] b1, output logic o1,
                     output logic [7:0] b2, output logic o2);
    cycle(3'h0, b1, o1);
    cycle(3'h0, b2, o2);
  endtask
endmodule
`default_nettype wire

// File: verification/cti_tb_top.sv
// self-checking testbench for the cascaded interrupt controller
`timescale 1ns/10ps
`default_nettype none
module cti_tb_top;
  import cti_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, o1, o2;
  logic pin_i, pin_o, pin_oe, pin_drv, dma_pin_n, dma_ch4, tmr2, tmr0;
  logic tmr3, chain, tc, m_io_n, d_c_n, w_r_n, ads_n, ready_n, data_oe;
  logic int_out;
  logic [7:0] paddr, data_out, b1, b2;
  logic [31:0] pwdata, prdata, r;
  logic [NEXT-1:0] ext_req_n;
  int mismatches, n_checks, cycles;
  assign pin_i = pin_oe ? pin_o : pin_drv;
  cti_top cti_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_req_n(ext_req_n), .shared_request_timer_pin_i(pin_i),
    .shared_request_timer_pin_o(pin_o),
    .shared_request_timer_pin_oe(pin_oe),
    .shared_request_dma_pin_n(dma_pin_n), .dma_request_ch_four(dma_ch4),
    .second_timer_output(tmr2), .timer0_out(tmr0), .timer3_out(tmr3),
    .dma_chain_req(chain), .dma_tc_req(tc), .m_io_n(m_io_n),
    .d_c_n(d_c_n), .w_r_n(w_r_n), .ads_n(ads_n), .ready_n(ready_n),
    .data_out(data_out), .data_oe(data_oe), .int_out(int_out));
  cti_host_model cti_host_model_inst (.pclk(pclk), .data_out(data_out),
    .data_oe(data_oe), .m_io_n(m_io_n), .d_c_n(d_c_n), .w_r_n(w_r_n),
    .ads_n(ads_n), .ready_n(ready_n));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask
  task automatic ackc(input logic [7:0] x1, input logic [8:0] x2);
    cti_host_model_inst.ack(b1, o1, b2, o2);
    chk({23'h0, o1, b1}, {23'h0, 1'b1, x1});
    chk({23'h0, o2, b2}, {23'h0, x2});
  endtask
  function automatic logic [7:0] breg(input int b, input logic [7:0] o);
    return OFF_BANK + BANK_STRIDE * 8'(b) + o;
  endfunction
  function automatic logic [7:0] vreg(input int i);
    return {VEC_FIRST_WORD + 6'(i), 2'b00};
  endfunction
  task automatic eoi(input logic [7:0] m0, input logic [7:0] m1);
    wr(breg(0, REG_EOI), {24'h0, m0});
    wr(breg(1, REG_EOI), {24'h0, m1});
  endtask
  task automatic settle;
    repeat (6) @(posedge pclk);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {ext_req_n, pin_drv, dma_pin_n} = '1;
    {tmr2, tmr0, tmr3, chain, tc} = '0;
    {mismatches, n_checks, cycles} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    settle;
    rdc(OFF_CTRL, 32'h0);
    rdc(OFF_PEND, 32'h0);
    rdc(OFF_INSVC, 32'h0);
    apb(1'b0, 8'hFC, 32'h0, r, e);
    chk({e, r[30:0]}, 32'h8000_0000);
    chk({31'h0, int_out}, 32'h0);
    for (int i = 0; i < NVEC; i++) wr(vreg(i), 32'h20 + i);
    rdc(vreg(NVEC - 1), 32'h38);
    ackc(FIRST_BYTE, 9'h127);
    rdc(OFF_INSVC, 32'h0);
    cti_host_model_inst.cycle(3'h4, b1, o1);
    chk({31'h0, o1}, 32'h0);
    ext_req_n[0] <= 1'b0;
    settle;
    rdc(OFF_PEND, 32'h0200_0804);
    chk({31'h0, int_out}, 32'h1);
    ackc(FIRST_BYTE, 9'h12B);
    rdc(OFF_INSVC, 32'h0000_0804);
    eoi(8'h04, 8'h08);
    rdc(OFF_INSVC, 32'h0);
    chain <= 1'b1;
    wr(breg(0, REG_MASK), 32'h02);
    settle;
    rdc(OFF_PEND, 32'h0200_0804);
    ackc(FIRST_BYTE, 9'h12B);
    eoi(8'h04, 8'h08);
    wr(breg(0, REG_MASK), 32'h0);
    settle;
    ackc(FIRST_BYTE, 9'h121);
    eoi(8'h02, 8'h00);
    chain <= 1'b0;
    wr(breg(1, REG_SLAVE), 32'h08);
    ackc(8'h2B, 9'h000);
    eoi(8'h04, 8'h08);
    wr(breg(1, REG_SLAVE), 32'h0);
    ext_req_n[0] <= 1'b1;
    wr(breg(0, REG_IW2), 32'h55);
    settle;
    rdc(OFF_PEND, 32'h0300_0004);
    ackc(FIRST_BYTE, 9'h138);
    eoi(8'h04, 8'h00);
    rdc(OFF_PEND, 32'h0300_0004);
    rdc(breg(0, REG_IW2), 32'h55);
    rdc(OFF_PEND, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(OFF_CTRL, {30'h0, k == 1 ? MODE_TMR_ONLY :
         (k == 2 ? MODE_TMR_REQ : MODE_REQ_ONLY)});
      tmr2 <= (k < 3);
      pin_drv <= (k < 3);
      settle;
      chk({31'h0, pin_oe}, {31'h0, k == 1 || k == 2});
      rdc(OFF_PEND, k > 1 ? 32'h0200_0008 : 32'h0);
    end
    tmr2 <= 1'b0;
    pin_drv <= 1'b1;
    wr(OFF_CTRL, 32'h4);
    dma_pin_n <= 1'b0;
    settle;
    chk({31'h0, dma_ch4}, 32'h0);
    dma_pin_n <= 1'b1;
    settle;
    chk({31'h0, dma_ch4}, 32'h1);
    wr(OFF_CTRL, 32'h0);
    dma_pin_n <= 1'b0;
    settle;
    rdc(OFF_PEND, 32'h0200_0204);
    dma_pin_n <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      tc <= (k == 0);
      tmr3 <= (k == 1);
      tmr0 <= (k == 2);
      settle;
      rdc(OFF_PEND, k == 0 ? 32'h0200_0010 :
          (k == 1 ? 32'h0200_0001 : 32'h0200_0104));
      {tc, tmr3, tmr0} <= 3'h0;
      wr(breg(k / 2, REG_MASK), {31'h0, k > 0});
      wr(breg(k / 2, REG_MASK), 32'h0);
      settle;
      rdc(OFF_PEND, 32'h0);
    end
    report_and_stop();
  end
endmodule
bind cti_top cti_checker cti_checker_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .m_io_n(m_io_n), .d_c_n(d_c_n), .w_r_n(w_r_n), .ads_n(ads_n),
  .ready_n(ready_n), .second_timer_output(second_timer_output),
  .shared_request_timer_pin_oe(shared_request_timer_pin_oe),
  .data_out(data_out), .data_oe(data_oe));
`default_nettype wire
